// *** logic/pp_edge_detect.sv ***
/*
 two-flop synchroniser and rising edge detector for asynchronous host lines.
 assumes lines come straight from pins; pulses are one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
module pp_edge_detect
   import pp_sig_pkg::*;
#(
   parameter int W = 4
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [W-1:0] i_lines,
   pp_edge_if.src edges
);
   logic [W-1:0] sync1_r;
   logic [W-1:0] sync2_r;
   logic [W-1:0] prev_r;
   logic [1:0] arm_r;

   // two flops before any logic reads the pins [RQ17]
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
      end else if (i_ce) begin
         sync1_r <= i_lines;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // suppress false edges while the synchroniser fills after reset
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         arm_r <= '0;
      end else if (i_ce && arm_r != EDGE_ARM_CYCLES) begin
         arm_r <= arm_r + 2'h1;
      end
   end

   // low to high against previous sample [RQ17]
   assign edges.rise = (arm_r == EDGE_ARM_CYCLES) ? (sync2_r & ~prev_r) : '0;
endmodule
`default_nettype wire

// *** logic/pp_edge_if.sv ***
/*
 interface carrying rising edge pulses of the host lines from the edge
 detector to the control block. assumes both ends share i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface pp_edge_if #(parameter int W = 4);
   logic [W-1:0] rise;
   modport src (output rise);
   modport dst (input rise);
endinterface
`default_nettype wire

// *** logic/pp_sig_pkg.sv ***
/*
 package of offsets, field positions, reset values and port modes for the
 parallel port signal control block. assumes an 8-bit register address space.
*/
package pp_sig_pkg;
   // register offsets
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h22;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h23;
   localparam logic [7:0] OFS_NEG_STATUS = 8'h24;
   localparam logic [7:0] OFS_OUT_VALUES = 8'h2b;
   localparam logic [7:0] OFS_EDGE_SEL = 8'h2d;
   // reset values
   localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] RST_OUT_VALUES = 8'h48;
   localparam logic [7:0] RST_EDGE_SEL = 8'h00;
   // interrupt register fields
   localparam int IRQ_TEST_BIT = 6;
   localparam int IRQ_NEG_CHANGE_BIT = 5;
   localparam int IRQ_SIG_CHANGE_BIT = 4;
   localparam int IRQ_SM_EVENTS = 4;
   // output value fields
   localparam int OUT_BUSY_BIT = 7;
   localparam int OUT_STROBE_BIT = 6;
   localparam int OUT_ACK_BIT = 5;
   localparam int OUT_EXT_FLAG_BIT = 4;
   localparam int OUT_DAVAIL_BIT = 3;
   localparam int OUT_LOW_USED = 3;
   // rising edge select fields
   localparam int SEL_ACTIVE_BIT = 3;
   localparam int SEL_INIT_BIT = 2;
   localparam int SEL_BUSY_BIT = 1;
   localparam int SEL_STROBE_BIT = 0;
   localparam int HOST_LINES = 4;
   // negotiation status fields
   localparam int NEG_CHANGED_BIT = 7;
   localparam int NEG_MODE_LSB = 0;
   // edge detector arming delay, cycles after reset
   localparam logic [1:0] EDGE_ARM_CYCLES = 2'h3;

   typedef enum logic [1:0] {
      MODE_MANUAL,
      MODE_COMPAT,
      MODE_EPP,
      MODE_ECP
   } mode_type;
endpackage

// *** logic/pp_signal_ctrl.sv ***
/*
 peripheral side control of parallel port status outputs, rising edge
 interrupts on host lines, negotiation change report and interrupt regs.
 assumes the port mode and state machine drives come from logic on i_mclk,
 host lines from pins, and a one-cycle strobe register port.
*/
// The plain strobed port was decided locally.
// How it works
// [RQ1] a port mode change raises an interrupt when its enable bit is set
// [RQ2] any write to negotiation status clears it
// [RQ3] selected host line rising raises signal change interrupt if enabled
// [RQ4] edge select bits: active 3, init 2, busy 1, strobe 0
// [RQ5] upper four edge select bits are written zero and read zero
// [RQ6] edge selections give no interrupt outside manual mode
// [RQ7] manual mode drives every output line straight from its register bit
// [RQ8] compatibility and epp: state machine drives busy and strobe, rest from register
// [RQ9] ecp mode ignores the output value register entirely
// [RQ10] busy bit 7 and strobe bit 6 control lines only in manual mode
// [RQ11] bit 5 drives ack data request line
// [RQ12] bit 4 drives extension flag line
// [RQ13] bit 3 drives data available active low line
// [RQ14] software writes zeros to output value bits 2 to 0
// [RQ15] each enable bit gates the same status bit
// [RQ16] any write to interrupt status clears it and drops the request
// [RQ17] host lines are synchronised then compared with previous sample
`timescale 1ns/1ps
`default_nettype none
module pp_signal_ctrl (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire pp_sig_pkg::mode_type i_port_mode,
   input wire logic [4:0] i_sm_lines,
   input wire logic [pp_sig_pkg::IRQ_SM_EVENTS-1:0] i_sm_events,
   input wire logic i_ieee_active_in,
   input wire logic i_host_init_n,
   input wire logic i_host_busy_in,
   input wire logic i_host_strobe_in,
   output logic o_periph_busy_out,
   output logic o_periph_strobe_out,
   output logic o_ack_data_request_out,
   output logic o_extension_flag_out,
   output logic o_data_available_n_out,
   output logic o_irq
);
   import pp_sig_pkg::*;

   logic [7:0] irq_enable_r;
   logic [7:0] out_values_r;
   logic [HOST_LINES-1:0] edge_sel_r;
   logic [7:0] neg_status_r;
   logic [7:0] irq_status;
   logic [7:0] irq_set;
   mode_type mode_prev_r;
   logic mode_seen_r;
   logic mode_change;
   logic manual;
   logic sig_change;
   logic wr_enable;
   logic wr_status;
   logic wr_neg;
   logic wr_out;
   logic wr_sel;
   logic [7:0] rdata_nxt;
   logic [HOST_LINES-1:0] host_lines;

   pp_edge_if #(.W(HOST_LINES)) edge_bus ();

   assign wr_enable = i_wr && i_addr == OFS_IRQ_ENABLE;
   assign wr_status = i_wr && i_addr == OFS_IRQ_STATUS;
   assign wr_neg = i_wr && i_addr == OFS_NEG_STATUS;
   assign wr_out = i_wr && i_addr == OFS_OUT_VALUES;
   assign wr_sel = i_wr && i_addr == OFS_EDGE_SEL;
   assign manual = i_port_mode == MODE_MANUAL;

   // host line packing [RQ4]
   always_comb begin
      host_lines = '0;
      host_lines[SEL_ACTIVE_BIT] = i_ieee_active_in;
      host_lines[SEL_INIT_BIT] = i_host_init_n;
      host_lines[SEL_BUSY_BIT] = i_host_busy_in;
      host_lines[SEL_STROBE_BIT] = i_host_strobe_in;
   end

   pp_edge_detect #(.W(HOST_LINES)) u_edges (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_lines(host_lines),
      .edges(edge_bus.src)
   );

   // selected rising edge only in manual mode
   assign sig_change = manual && |(edge_bus.rise & edge_sel_r); // [RQ3] [RQ6]

   // mode change detect, ignoring the first cycle after reset
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         mode_prev_r <= MODE_MANUAL;
         mode_seen_r <= 1'b0;
      end else if (i_ce) begin
         mode_prev_r <= i_port_mode;
         mode_seen_r <= 1'b1;
      end
   end
   assign mode_change = mode_seen_r && i_port_mode != mode_prev_r;

   // interrupt enable register, bit 7 reads zero
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         irq_enable_r <= RST_IRQ_ENABLE;
      end else if (i_ce && wr_enable) begin
         irq_enable_r <= {1'b0, i_wdata[6:0]};
      end
   end

   // output value register, low bits kept zero [RQ14]
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         out_values_r <= RST_OUT_VALUES;
      end else if (i_ce && wr_out) begin
         out_values_r <= {i_wdata[7:OUT_LOW_USED], {OUT_LOW_USED{1'b0}}};
      end
   end

   // edge select register, upper bits not stored [RQ5]
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         edge_sel_r <= RST_EDGE_SEL[HOST_LINES-1:0];
      end else if (i_ce && wr_sel) begin
         edge_sel_r <= i_wdata[HOST_LINES-1:0];
      end
   end

   // negotiation status: new mode and change flag, any write clears
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         neg_status_r <= '0;
      end else if (i_ce) begin
         if (mode_change) begin
            neg_status_r <= '0;
            neg_status_r[NEG_CHANGED_BIT] <= 1'b1;
            neg_status_r[NEG_MODE_LSB +: 2] <= i_port_mode;
         end else if (wr_neg) begin
            neg_status_r <= '0; // [RQ2]
         end
      end
   end

   // event sources for interrupt status
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_NEG_CHANGE_BIT] = mode_change; // [RQ1]
      irq_set[IRQ_SIG_CHANGE_BIT] = sig_change; // [RQ3]
      irq_set[IRQ_SM_EVENTS-1:0] = i_sm_events;
   end

   pp_sticky_flags #(.W(8)) u_status (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_set(irq_set),
      .i_clr(wr_status), // [RQ16]
      .o_flags(irq_status)
   );

   // interrupt request, each enable gates its own status bit
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_irq <= 1'b0;
      end else if (i_ce) begin
         o_irq <= |((((irq_status & ~{8{wr_status}}) | irq_set)) & irq_enable_r); // [RQ15] [RQ1] [RQ16]
      end
   end

   // output line ownership by mode
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_periph_busy_out <= RST_OUT_VALUES[OUT_BUSY_BIT];
         o_periph_strobe_out <= RST_OUT_VALUES[OUT_STROBE_BIT];
         o_ack_data_request_out <= RST_OUT_VALUES[OUT_ACK_BIT];
         o_extension_flag_out <= RST_OUT_VALUES[OUT_EXT_FLAG_BIT];
         o_data_available_n_out <= RST_OUT_VALUES[OUT_DAVAIL_BIT];
      end else if (i_ce) begin
         case (i_port_mode)
            MODE_MANUAL: begin
               o_periph_busy_out <= out_values_r[OUT_BUSY_BIT]; // [RQ7] [RQ10]
               o_periph_strobe_out <= out_values_r[OUT_STROBE_BIT]; // [RQ7] [RQ10]
               o_ack_data_request_out <= out_values_r[OUT_ACK_BIT]; // [RQ7] [RQ11]
               o_extension_flag_out <= out_values_r[OUT_EXT_FLAG_BIT]; // [RQ7] [RQ12]
               o_data_available_n_out <= out_values_r[OUT_DAVAIL_BIT]; // [RQ7] [RQ13]
            end
            MODE_COMPAT, MODE_EPP: begin
               o_periph_busy_out <= i_sm_lines[4]; // [RQ8]
               o_periph_strobe_out <= i_sm_lines[3]; // [RQ8]
               o_ack_data_request_out <= out_values_r[OUT_ACK_BIT]; // [RQ11]
               o_extension_flag_out <= out_values_r[OUT_EXT_FLAG_BIT]; // [RQ12]
               o_data_available_n_out <= out_values_r[OUT_DAVAIL_BIT]; // [RQ13]
            end
            default: begin
               o_periph_busy_out <= i_sm_lines[4]; // [RQ9]
               o_periph_strobe_out <= i_sm_lines[3]; // [RQ9]
               o_ack_data_request_out <= i_sm_lines[2]; // [RQ9]
               o_extension_flag_out <= i_sm_lines[1]; // [RQ9]
               o_data_available_n_out <= i_sm_lines[0]; // [RQ9]
            end
         endcase
      end
   end

   // read mux; output values are write only
   always_comb begin
      rdata_nxt = '0;
      case (i_addr)
         OFS_IRQ_ENABLE: rdata_nxt = irq_enable_r;
         OFS_IRQ_STATUS: rdata_nxt = irq_status;
         OFS_NEG_STATUS: rdata_nxt = neg_status_r;
         OFS_EDGE_SEL: rdata_nxt = {{(8 - HOST_LINES){1'b0}}, edge_sel_r}; // [RQ5]
         default: rdata_nxt = '0;
      endcase
   end

   // read data stands one cycle only
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_rdata <= '0;
      end else if (i_ce) begin
         o_rdata <= i_rd ? rdata_nxt : '0;
      end
   end
endmodule
`default_nettype wire

// *** logic/pp_sticky_flags.sv ***
/*
 bank of sticky event flags with a clear-all pulse; a set in the clear
 cycle wins. assumes set and clear are on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pp_sticky_flags #(
   parameter int W = 8
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [W-1:0] i_set,
   input wire logic i_clr,
   output logic [W-1:0] o_flags
);
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_flags <= '0;
      end else if (i_ce) begin
         o_flags <= (o_flags & ~{W{i_clr}}) | i_set;
      end
   end
endmodule
`default_nettype wire

// *** tb/pp_host_model.sv ***
/* host port model driving the four host lines.
 assumes lines are async to the block clock; a cable delay applies. */
`timescale 1ns/1ps
`default_nettype none
module pp_host_model #(
   parameter real DLY = 7.3
) (
   input wire logic [3:0] i_lvl,
   output logic [3:0] o_lines
);
   initial o_lines = 4'h0;
   // lines follow the request after a delay unrelated to the clock
   always @(i_lvl) o_lines <= #(DLY) i_lvl;
endmodule
`default_nettype wire

// *** tb/pp_sig_props.sv ***
/* port checker of the parallel port signal control block.
 assumes it is bound to pp_signal_ctrl; i_ce low pauses it. */
`timescale 1ns/1ps
`default_nettype none
module pp_sig_props
   import pp_sig_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire pp_sig_pkg::mode_type i_port_mode,
   input wire logic [4:0] i_sm_lines,
   input wire logic [pp_sig_pkg::IRQ_SM_EVENTS-1:0] i_sm_events,
   input wire logic o_periph_busy_out,
   input wire logic o_periph_strobe_out,
   input wire logic o_ack_data_request_out,
   input wire logic o_extension_flag_out,
   input wire logic o_data_available_n_out,
   input wire logic o_irq
);
   wire logic [4:0] ln = {o_periph_busy_out, o_periph_strobe_out, o_ack_data_request_out,
      o_extension_flag_out, o_data_available_n_out};
   wire logic man = i_port_mode == MODE_MANUAL;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst || !i_ce);
   property p_sel_hi; i_rd && i_addr == OFS_EDGE_SEL |=> o_rdata[7:4] == 4'h0; endproperty
   a_sel_hi: assert property (p_sel_hi) else $error("edge select upper bits");
   property p_st_hi; i_rd && i_addr == OFS_IRQ_STATUS |=> o_rdata[7:6] == 2'h0; endproperty
   a_st_hi: assert property (p_st_hi) else $error("status upper bits");
   property p_clr;
      i_wr && i_addr == OFS_IRQ_STATUS && i_sm_events == 4'h0 && !man && $stable(i_port_mode)
      |=> !o_irq;
   endproperty
   a_clr: assert property (p_clr) else $error("irq after status clear");
   property p_hold; man && $past(man) && !$past(i_wr) |=> $stable(ln); endproperty
   a_hold: assert property (p_hold) else $error("manual lines moved");
   property p_cmp;
      i_port_mode == MODE_COMPAT || i_port_mode == MODE_EPP |=> ln[4:3] == $past(i_sm_lines[4:3]);
   endproperty
   a_cmp: assert property (p_cmp) else $error("busy strobe not from state machine");
   property p_ecp; i_port_mode == MODE_ECP |=> ln == $past(i_sm_lines); endproperty
   a_ecp: assert property (p_ecp) else $error("ecp lines");
   property p_neg;
      $changed(i_port_mode) && !$past(i_srst) && !$past(i_srst, 2) ##1
      i_rd && i_addr == OFS_NEG_STATUS && $stable(i_port_mode)
      |=> o_rdata[7] && o_rdata[1:0] == $past(i_port_mode);
   endproperty
   a_neg: assert property (p_neg) else $error("mode change not reported");
   property p_negc;
      i_wr && i_addr == OFS_NEG_STATUS && $stable(i_port_mode) ##1
      i_rd && i_addr == OFS_NEG_STATUS && $stable(i_port_mode) |=> !o_rdata[7];
   endproperty
   a_negc: assert property (p_negc) else $error("negotiation status kept");
endmodule
bind pp_signal_ctrl pp_sig_props chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce),
   .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_mode(i_port_mode),
   .i_sm_lines(i_sm_lines), .i_sm_events(i_sm_events), .o_periph_busy_out(o_periph_busy_out),
   .o_periph_strobe_out(o_periph_strobe_out), .o_ack_data_request_out(o_ack_data_request_out),
   .o_extension_flag_out(o_extension_flag_out),
   .o_data_available_n_out(o_data_available_n_out), .o_irq(o_irq));
`default_nettype wire

// *** tb/pp_signal_ctrl_test.sv ***
/* self-checking bench of pp_signal_ctrl.
 assumes the checker bind and the host line model are compiled. */
`timescale 1ns/1ps
`default_nettype none
module pp_signal_ctrl_test;
   import pp_sig_pkg::*;
   logic i_mclk = 1'h0, i_srst = 1'h1, i_ce = 1'h1, i_wr = 1'h0, i_rd = 1'h0, rd_d = 1'h0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, v;
   logic [4:0] i_sm_lines = 5'h00, el, ol;
   logic [3:0] i_sm_events = 4'h0, lvl = 4'h0, host;
   logic o_irq;
   mode_type i_port_mode = MODE_MANUAL;
   logic [7:0] q_exp[$], q_msk[$];
   int n_errors = 0, num_checks = 0, seed;
   always #12.5 i_mclk = ~i_mclk;
   pp_signal_ctrl dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_mode(i_port_mode),
      .i_sm_lines(i_sm_lines), .i_sm_events(i_sm_events), .i_ieee_active_in(host[3]),
      .i_host_init_n(host[2]), .i_host_busy_in(host[1]), .i_host_strobe_in(host[0]),
      .o_periph_busy_out(ol[4]), .o_periph_strobe_out(ol[3]), .o_ack_data_request_out(ol[2]),
      .o_extension_flag_out(ol[1]), .o_data_available_n_out(ol[0]), .o_irq(o_irq));
   pp_host_model hm (.i_lvl(lvl), .o_lines(host));
   task automatic note(input logic bad, input string what);
      num_checks++;
      if (bad) begin
         n_errors++;
         $display("ERROR %0t %s mismatch", $time, what);
      end
   endtask
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      i_wr <= w;
      i_rd <= r;
      i_addr <= a;
      i_wdata <= d;
      i_sm_lines <= 5'($urandom);
      @(posedge i_mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      q_exp.push_back(e & m);
      q_msk.push_back(m);
      bus(1'h0, 1'h1, a, 8'h00);
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'h0, 1'h0, 8'h00, 8'h00);
   endtask
   task automatic settle;
      i_wr <= 1'h0;
      i_rd <= 1'h0;
      @(negedge i_mclk);
   endtask
   task automatic chk_lines(input logic [4:0] e);
      settle;
      note(ol !== e, "lines");
      @(posedge i_mclk);
   endtask
   task automatic chk_irq(input logic e);
      settle;
      note(o_irq !== e, "irq");
      @(posedge i_mclk);
   endtask
   // read results arrive one cycle after the strobe
   always @(posedge i_mclk) begin
      rd_d <= i_rd;
      if (rd_d) begin
         note((o_rdata & q_msk[0]) !== q_exp[0], "read");
         void'(q_exp.pop_front());
         void'(q_msk.pop_front());
      end
   end
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_mclk);
      n_errors++;
      final_report;
   end
   initial begin
      seed = $urandom(87618);
      repeat (2) @(posedge i_mclk);
      i_srst <= 1'h0;
      chk_lines(RST_OUT_VALUES[7:3]);
      rd(OFS_IRQ_ENABLE, RST_IRQ_ENABLE, 8'hff);
      rd(OFS_EDGE_SEL, RST_EDGE_SEL, 8'hff);
      rd(OFS_OUT_VALUES, 8'h00, 8'hff);
      rd(8'h30, 8'h00, 8'hff);
      v = 8'($urandom);
      bus(1'h1, 1'h0, OFS_IRQ_ENABLE, v);
      bus(1'h1, 1'h0, OFS_EDGE_SEL, v & 8'h0f);
      rd(OFS_IRQ_ENABLE, v & 8'h7f, 8'hff);
      rd(OFS_EDGE_SEL, v & 8'h0f, 8'hff);
      bus(1'h1, 1'h0, OFS_IRQ_ENABLE, 8'h20);
      bus(1'h1, 1'h0, OFS_IRQ_STATUS, 8'h00);
      for (int i = 0; i < 4; i++) begin
         i_port_mode <= mode_type'((i + 1) % 4);
         idle(1);
         rd(OFS_NEG_STATUS, 8'h80 | 8'(i_port_mode), 8'h83);
         chk_irq(1'h1);
         bus(1'h1, 1'h0, OFS_NEG_STATUS, 8'h00);
         rd(OFS_NEG_STATUS, 8'h00, 8'h80);
         bus(1'h1, 1'h0, OFS_IRQ_STATUS, 8'h00);
         chk_irq(1'h0);
         v = 8'($urandom) & 8'hf8;
         bus(1'h1, 1'h0, OFS_OUT_VALUES, v);
         idle(1);
         el = i_port_mode == MODE_ECP ? i_sm_lines : v[7:3];
         if (i_port_mode == MODE_COMPAT || i_port_mode == MODE_EPP) el[4:3] = i_sm_lines[4:3];
         chk_lines(el);
      end
      i_port_mode <= MODE_COMPAT;
      for (int i = 0; i < 2; i++) begin
         bus(1'h1, 1'h0, OFS_IRQ_ENABLE, i == 0 ? 8'h0f : 8'h00);
         bus(1'h1, 1'h0, OFS_IRQ_STATUS, 8'h00);
         v = 8'($urandom % 15 + 1);
         i_sm_events <= v[3:0];
         idle(1);
         i_sm_events <= 4'h0;
         chk_irq(i == 0);
         rd(OFS_IRQ_STATUS, v, 8'h0f);
      end
      i_port_mode <= MODE_MANUAL;
      bus(1'h1, 1'h0, OFS_IRQ_ENABLE, 8'h10);
      for (int k = 0; k < 5; k++) begin
         bus(1'h1, 1'h0, OFS_EDGE_SEL, k < 4 ? 8'h01 << k : 8'h0f);
         if (k == 4) i_port_mode <= MODE_ECP;
         bus(1'h1, 1'h0, OFS_IRQ_STATUS, 8'h00);
         lvl = k < 4 ? 4'h1 << ((k + 1) % 4) : 4'hf;
         idle(8);
         chk_irq(1'h0);
         lvl = k < 4 ? lvl | (4'h1 << k) : lvl;
         idle(8);
         chk_irq(k < 4);
         rd(OFS_IRQ_STATUS, k < 4 ? 8'h10 : 8'h00, 8'h10);
         lvl = 4'h0;
         idle(8);
      end
      // clock enable low must hold the output value register and every line
      i_port_mode <= MODE_MANUAL;
      bus(1'h1, 1'h0, OFS_OUT_VALUES, 8'hf8);
      idle(1);
      i_ce <= 1'h0;
      bus(1'h1, 1'h0, OFS_OUT_VALUES, 8'h00);
      idle(2);
      i_ce <= 1'h1;
      chk_lines(5'h1f);
      final_report;
   end
endmodule
`default_nettype wire
